// [hdr_pack.sv]
// Registered transport header serialiser
`timescale 1ns/1ns
module hdr_pack (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Header fields
  input wire logic load,
  input wire logic [1:0] tt,
  input wire logic [3:0] ftype,
  input wire logic [15:0] target_identifier,
  input wire logic [15:0] origin_identifier,
  input wire logic [7:0] hop_count,
  // Serialised header
  output logic valid_q,
  output logic [55:0] hdr_q,
  output logic [5:0] len_q
);

  // ----------------------------------------
  // Field ordering
  // ----------------------------------------
  logic [55:0] small_hdr;
  logic [55:0] wide_hdr;
  logic [55:0] hdr_d;
  logic [5:0] len_d;

  // Format nibble sits once, right behind the type code
  assign small_hdr = {tt, ftype, target_identifier[7:0], origin_identifier[7:0],
                      hop_count, 26'h000_0000};
  assign wide_hdr = {tt, ftype, target_identifier, origin_identifier,
                     hop_count, 10'h000};
  assign hdr_d = (tt == transport_pkg::TT_WIDE) ? wide_hdr : small_hdr;
  assign len_d = (tt == transport_pkg::TT_WIDE) ? transport_pkg::HDR_WIDE_LEN
                                                : transport_pkg::HDR_SMALL_LEN;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
      hdr_q <= '0;
      len_q <= '0;
    end else begin
      valid_q <= load;
      if (load) begin
        hdr_q <= hdr_d;
        len_q <= len_d;
      end
    end
  end

endmodule

// [requester_model.sv]
// Requesting element that issues maintenance requests
`timescale 1ns/1ns
module requester_model (
  // Clock
  input wire logic mclk,
  // Request
  output logic rx_valid,
  output logic [1:0] rx_tt,
  output logic [3:0] rx_ftype,
  output logic [15:0] rx_target_identifier,
  output logic [15:0] rx_origin_identifier,
  output logic [7:0] rx_hop_count,
  output logic rx_write,
  output logic [23:0] rx_offset,
  output logic [31:0] rx_wdata
);
  initial begin
    rx_valid = 1'b0;
    {rx_tt, rx_ftype, rx_target_identifier, rx_origin_identifier} = '0;
    {rx_hop_count, rx_write, rx_offset, rx_wdata} = '0;
  end
  // Fields held until the taking edge
  task automatic send(input logic [1:0] tt, input logic [3:0] ft, input logic [15:0] tgt,
      input logic [7:0] hop, input logic w_en, input logic [23:0] off, input logic [31:0] wd);
    @(posedge mclk);
    #1;
    rx_valid = 1'b1;
    {rx_tt, rx_ftype, rx_target_identifier, rx_hop_count} = {tt, ft, tgt, hop};
    {rx_write, rx_offset, rx_wdata} = {w_en, off, wd};
    rx_origin_identifier = 16'($urandom);
  endtask
  // Idle data and offset lines flip so stale data is never mistaken for a request
  task automatic idle;
    @(posedge mclk);
    #1;
    rx_valid = 1'b0;
    rx_wdata = ~rx_wdata;
    rx_offset = ~rx_offset;
  endtask
endmodule

// [testbench.sv]
// Self-checking bench for the transport configuration block
`timescale 1ns/1ns
module testbench;
  // Bit 27 counted from the top
  localparam logic [31:0] FEAT = 32'h0000_0010;
  localparam logic [34:0] DROP = {3'h1, 32'h0};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_valid, rx_write, rsp_valid, rsp_write_q, fwd_valid, discard_q, sw_rsp, sw_fwd, sw_drop;
  logic [1:0] rx_tt;
  logic [3:0] rx_ftype;
  logic [15:0] rx_target_identifier, rx_origin_identifier;
  logic [7:0] rx_hop_count, small_own_identifier_q;
  logic [23:0] rx_offset;
  logic [31:0] rx_wdata, rsp_rdata_q, sw_rdata;
  logic [55:0] rsp_header, fwd_header, sw_fwd_header;
  logic [5:0] rsp_header_len;
  logic sel_sw = 1'b0;
  logic [34:0] notes[$];
  logic [34:0] seen;
  logic [23:0] ids = 24'hFF_FFFF;
  int fails = 0;
  int checked = 0;
  always #50 mclk = ~mclk;
  requester_model rqm (.mclk, .rx_valid, .rx_tt, .rx_ftype, .rx_target_identifier,
    .rx_origin_identifier, .rx_hop_count, .rx_write, .rx_offset, .rx_wdata);
  transport_cfg dut (.mclk, .rst_n, .rx_valid, .rx_tt, .rx_ftype, .rx_target_identifier,
    .rx_origin_identifier, .rx_hop_count, .rx_write, .rx_offset, .rx_wdata, .rsp_valid,
    .rsp_header, .rsp_header_len, .rsp_write_q, .rsp_rdata_q, .fwd_valid, .fwd_header,
    .fwd_header_len(), .fwd_target_identifier_q(), .fwd_write_q(), .fwd_offset_q(),
    .fwd_wdata_q(), .discard_q, .small_own_identifier_q, .wide_own_identifier_q());
  transport_cfg #(.SWITCH_NO_ID(1)) dut_sw (.mclk, .rst_n, .rx_valid, .rx_tt, .rx_ftype,
    .rx_target_identifier, .rx_origin_identifier, .rx_hop_count, .rx_write, .rx_offset,
    .rx_wdata, .rsp_valid(sw_rsp), .rsp_header(), .rsp_header_len(), .rsp_write_q(),
    .rsp_rdata_q(sw_rdata), .fwd_valid(sw_fwd), .fwd_header(sw_fwd_header),
    .fwd_header_len(), .fwd_target_identifier_q(), .fwd_write_q(), .fwd_offset_q(),
    .fwd_wdata_q(), .discard_q(sw_drop), .small_own_identifier_q(), .wide_own_identifier_q());
  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic req(input logic [1:0] tt, input logic [3:0] ft, input logic [15:0] tgt,
      input logic [7:0] hop, input logic w_en, input logic [23:0] off, input logic [31:0] wd,
      input logic [34:0] exp);
    notes.push_back(exp);
    rqm.send(tt, ft, tgt, hop, w_en, off, wd);
  endtask
  // Upper target byte is noise: small format looks at eight bits only
  task automatic rd(input logic [23:0] off, input logic [31:0] d);
    req(2'h0, 4'h8, {8'($urandom), ids[23:16]}, 8'h00, 1'b0, off, 32'h0, {3'h4, d});
  endtask
  task automatic wr(input logic [23:0] off, input logic [31:0] d);
    req(2'h0, 4'h8, {8'($urandom), ids[23:16]}, 8'h00, 1'b1, off, d, {3'h4, 32'h0});
  endtask
  task automatic drain(input string name);
    int n;
    rqm.idle();
    n = 0;
    while (notes.size() != 0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (notes.size() != 0) begin
      fails++;
      give_verdict();
    end
    else $display("done %s", name);
  endtask
  function automatic logic [34:0] obs(input logic v, input logic f, input logic d,
      input logic [31:0] rd_data, input logic [55:0] fh);
    return {v, f, d, v ? rd_data : f ? {24'h0, fh[33:26]} : 32'h0};
  endfunction
  always @(negedge mclk) begin
    seen = sel_sw ? obs(sw_rsp, sw_fwd, sw_drop, sw_rdata, sw_fwd_header)
      : obs(rsp_valid, fwd_valid, discard_q, rsp_rdata_q, fwd_header);
    if (seen[34:32] !== 3'h0) begin
      if (notes.size() == 0) chk(seen, 35'h0);
      else chk(seen, notes.pop_front());
    end
  end
  // ------------------------------
  // Stimulus
  // ------------------------------
  initial begin
    logic [31:0] w;
    logic [23:0] offs[9] = '{24'h00_0010, 24'h00_0000, 24'h00_003C, 24'h00_0040, 24'h00_00FC,
      24'h00_0100, 24'h00_FFFC, 24'h01_0000, 24'hFF_FFFC};
    logic [7:0] hops[3] = '{8'h01, 8'h05, 8'hFF};
    void'($urandom(59891));
    repeat (3) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    rd(24'h00_0010, FEAT);
    rd(24'h00_0060, {8'h00, ids});
    drain("reset values");
    repeat (3) begin
      w = $urandom;
      w[31:24] = 8'h00;
      wr(24'h00_0060, w);
      ids = w[23:0];
      rd(24'h00_0060, {8'h00, ids});
      req(2'h1, 4'h8, ids[15:0], 8'h00, 1'b0, 24'h00_0010, 32'h0, {3'h4, FEAT});
    end
    drain("identifier write");
    foreach (offs[i]) begin
      wr(offs[i], $urandom);
      rd(offs[i], offs[i] == 24'h00_0010 ? FEAT : 32'h0);
    end
    wr(24'h00_0060, {8'($urandom), ids});
    rd(24'h00_0060, {8'h00, ids});
    drain("reserved space");
    for (int k = 2; k < 4; k++) begin
      req(2'(k), 4'h8, {8'h00, ids[23:16]}, 8'h00, 1'b0, 24'h00_0010, 32'h0, DROP);
    end
    req(2'h0, 4'h2, {8'h00, ids[23:16]}, 8'h00, 1'b0, 24'h00_0010, 32'h0, DROP);
    req(2'h0, 4'h8, {8'h00, ~ids[23:16]}, 8'h00, 1'b0, 24'h00_0010, 32'h0, DROP);
    drain("refusals");
    sel_sw = 1'b1;
    req(2'h0, 4'h8, 16'($urandom), 8'h00, 1'b0, 24'h00_0010, 32'h0, {3'h4, FEAT});
    foreach (hops[i]) begin
      req(2'h0, 4'h8, 16'($urandom), hops[i], 1'b0, 24'h00_0010, 32'h0,
        {3'h2, 24'h0, hops[i] - 8'h01});
    end
    drain("hop forwarding");
    give_verdict();
  end
endmodule
bind transport_cfg transport_checker chk (.mclk, .rst_n, .rx_valid, .rx_tt,
  .rx_origin_identifier, .rx_hop_count, .rx_write, .rx_offset, .rx_target_identifier,
  .rx_wdata, .rsp_valid, .rsp_header, .rsp_header_len, .rsp_write_q, .rsp_rdata_q,
  .fwd_valid, .fwd_header, .fwd_header_len, .fwd_target_identifier_q, .fwd_write_q,
  .fwd_offset_q, .fwd_wdata_q, .discard_q, .small_own_identifier_q);

// [transport_cfg.sv]
// Maintenance handling, hop forwarding and transport configuration registers
`timescale 1ns/1ns
module transport_cfg #(
  parameter int unsigned LARGE_SUPPORT = 1,
  parameter int unsigned SWITCH_NO_ID = 0,
  parameter logic [7:0] SMALL_ID_RESET = 8'hFF,
  parameter logic [15:0] WIDE_ID_RESET = 16'hFFFF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Received maintenance request
  input wire logic rx_valid,
  input wire logic [1:0] rx_tt,
  input wire logic [3:0] rx_ftype,
  input wire logic [15:0] rx_target_identifier,
  input wire logic [15:0] rx_origin_identifier,
  input wire logic [7:0] rx_hop_count,
  input wire logic rx_write,
  input wire logic [23:0] rx_offset,
  input wire logic [31:0] rx_wdata,
  // Response to send back
  output logic rsp_valid,
  output logic [55:0] rsp_header,
  output logic [5:0] rsp_header_len,
  output logic rsp_write_q,
  output logic [31:0] rsp_rdata_q,
  // Packet forwarded onward
  output logic fwd_valid,
  output logic [55:0] fwd_header,
  output logic [5:0] fwd_header_len,
  output logic [15:0] fwd_target_identifier_q,
  output logic fwd_write_q,
  output logic [23:0] fwd_offset_q,
  output logic [31:0] fwd_wdata_q,
  // Status
  output logic discard_q,
  output logic [7:0] small_own_identifier_q,
  output logic [15:0] wide_own_identifier_q
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (LARGE_SUPPORT > 1) begin : g_bad_large
    $error("LARGE_SUPPORT must be 0 or 1");
  end
  if (SWITCH_NO_ID > 1) begin : g_bad_switch
    $error("SWITCH_NO_ID must be 0 or 1");
  end
  if (transport_pkg::SMALL_ID_COUNT != (1 << transport_pkg::SMALL_ID_W) ||
      transport_pkg::WIDE_ID_COUNT != (1 << transport_pkg::WIDE_ID_W)) begin : g_bad_ids
    $error("Identifier widths do not match device counts");
  end

  // ----------------------------------------
  // Layout checks
  // ----------------------------------------
  // Port widths are fixed, so the package must keep to them
  if (transport_pkg::HDR_W != 56 || transport_pkg::HDR_LEN_W != 6) begin : g_bad_hdr_w
    $error("Header port widths do not match the package");
  end
  if (transport_pkg::REG_W != 32 || transport_pkg::OFFSET_W != 24) begin : g_bad_reg_w
    $error("Register or offset width does not match the ports");
  end
  if (transport_pkg::TT_W != 2 || transport_pkg::FTYPE_W != 4 ||
      transport_pkg::HOP_W != 8) begin : g_bad_fields
    $error("Header field widths do not match the ports");
  end
  if (int'(transport_pkg::HDR_WIDE_LEN) != transport_pkg::TT_W + transport_pkg::FTYPE_W +
      2 * transport_pkg::WIDE_ID_W + transport_pkg::HOP_W) begin : g_bad_wide_len
    $error("Wide header length does not match its fields");
  end
  if (int'(transport_pkg::HDR_SMALL_LEN) != transport_pkg::TT_W + transport_pkg::FTYPE_W +
      2 * transport_pkg::SMALL_ID_W + transport_pkg::HOP_W) begin : g_bad_small_len
    $error("Small header length does not match its fields");
  end
  if (int'(transport_pkg::HDR_WIDE_LEN) > transport_pkg::HDR_W) begin : g_bad_hdr_fit
    $error("Wide header does not fit the header port");
  end
  // Both identifier fields must sit inside the word without overlapping
  if (transport_pkg::SMALL_ID_HI >= transport_pkg::REG_W ||
      transport_pkg::WIDE_ID_HI >= transport_pkg::SMALL_ID_HI - transport_pkg::SMALL_ID_W + 1 ||
      transport_pkg::WIDE_ID_HI < transport_pkg::WIDE_ID_W - 1) begin : g_bad_id_fields
    $error("Identifier fields overlap or leave the register");
  end
  if (transport_pkg::FEAT_LARGE_POS < 0 ||
      transport_pkg::FEAT_LARGE_POS >= transport_pkg::REG_W) begin : g_bad_feat_pos
    $error("Large support flag lies outside the register");
  end
  // Space decode relies on the areas following each other in order
  if (transport_pkg::CAR_LAST >= transport_pkg::CSR_LAST ||
      transport_pkg::CSR_LAST >= transport_pkg::EXT_LAST) begin : g_bad_spaces
    $error("Configuration areas out of order");
  end
  if (transport_pkg::OFF_FEATURES > transport_pkg::CAR_LAST ||
      transport_pkg::OFF_OWN_ID <= transport_pkg::CAR_LAST ||
      transport_pkg::OFF_OWN_ID > transport_pkg::CSR_LAST) begin : g_bad_offsets
    $error("Register offsets outside their areas");
  end

  localparam logic LARGE_ON = (LARGE_SUPPORT == 1);
  localparam logic SWITCH_ON = (SWITCH_NO_ID == 1);

  // ----------------------------------------
  // Space decode
  // ----------------------------------------
  function automatic transport_pkg::space_t space_of(input logic [23:0] off);
    transport_pkg::space_t s;
    if (off <= transport_pkg::CAR_LAST) begin
      s = transport_pkg::SPACE_CAR;
    end else if (off <= transport_pkg::CSR_LAST) begin
      s = transport_pkg::SPACE_CSR;
    end else if (off <= transport_pkg::EXT_LAST) begin
      s = transport_pkg::SPACE_EXT;
    end else begin
      s = transport_pkg::SPACE_IMPL;
    end
    return s;
  endfunction

  // ----------------------------------------
  // Request classification
  // ----------------------------------------
  logic tt_ok;
  logic tt_wide;
  logic is_maint;
  logic id_match;
  logic hop_zero;
  logic addressed;
  logic local_acc;
  logic fwd_go;
  logic dropped;

  // Reserved codes are never accepted nor echoed back
  assign tt_ok = (rx_tt == transport_pkg::TT_SMALL) ||
                 (rx_tt == transport_pkg::TT_WIDE);
  assign tt_wide = (rx_tt == transport_pkg::TT_WIDE);
  assign is_maint = (rx_ftype == transport_pkg::MAINT_FTYPE);
  // Wide packets only match when the wide identifier is supported
  assign id_match = tt_wide ? (LARGE_ON && rx_target_identifier == wide_own_identifier_q)
                            : (rx_target_identifier[7:0] == small_own_identifier_q);
  assign hop_zero = (rx_hop_count == 8'h00);
  assign addressed = SWITCH_ON ? hop_zero : id_match;
  assign local_acc = rx_valid && tt_ok && is_maint && addressed;
  assign fwd_go = rx_valid && tt_ok && is_maint && SWITCH_ON && !hop_zero;
  assign dropped = rx_valid && !local_acc && !fwd_go;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic [23:0] word_off;
  transport_pkg::space_t space;
  logic sel_features;
  logic sel_own_id;
  logic own_id_wr;

  // Byte lanes below a word are ignored: every access is one whole word
  assign word_off = {rx_offset[23:2], 2'b00};
  assign space = space_of(word_off);
  assign sel_features = (word_off == transport_pkg::OFF_FEATURES);
  assign sel_own_id = (word_off == transport_pkg::OFF_OWN_ID);
  // Capability space has no writable bit, so writes there just complete
  assign own_id_wr = local_acc && rx_write && sel_own_id &&
                     (space == transport_pkg::SPACE_CSR);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] feat_word;
  logic [31:0] id_word;
  logic [31:0] rd_word;

  always_comb begin
    feat_word = '0;
    feat_word[transport_pkg::FEAT_LARGE_POS] = LARGE_ON;
  end

  always_comb begin
    id_word = '0;
    id_word[transport_pkg::SMALL_ID_HI -: 8] = small_own_identifier_q;
    // Wide field reads zero when the device cannot use it
    id_word[transport_pkg::WIDE_ID_HI -: 16] = LARGE_ON ? wide_own_identifier_q
                                                        : 16'h0000;
  end

  // Unmapped and implementation space read zero and still answer
  always_comb begin
    case (space)
      transport_pkg::SPACE_CAR: rd_word = sel_features ? feat_word : '0;
      transport_pkg::SPACE_CSR: rd_word = sel_own_id ? id_word : '0;
      transport_pkg::SPACE_EXT: rd_word = '0;
      transport_pkg::SPACE_IMPL: rd_word = '0;
      default: rd_word = '0;
    endcase
  end

  // ----------------------------------------
  // Identifier register
  // ----------------------------------------
  logic [7:0] small_id_d;
  logic [15:0] wide_id_d;

  assign small_id_d = own_id_wr ? rx_wdata[transport_pkg::SMALL_ID_HI -: 8]
                                : small_own_identifier_q;
  assign wide_id_d = (own_id_wr && LARGE_ON) ? rx_wdata[transport_pkg::WIDE_ID_HI -: 16]
                                             : wide_own_identifier_q;

  // Reset values are parameters so each board can choose its own
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      small_own_identifier_q <= SMALL_ID_RESET;
      wide_own_identifier_q <= WIDE_ID_RESET;
    end else begin
      small_own_identifier_q <= small_id_d;
      wide_own_identifier_q <= wide_id_d;
    end
  end

  // ----------------------------------------
  // Response
  // ----------------------------------------
  logic [15:0] rsp_origin;
  logic [15:0] rsp_target;

  // Identifiers swap ends so the answer returns to the requester
  assign rsp_target = tt_wide ? rx_origin_identifier
                              : {8'h00, rx_origin_identifier[7:0]};
  assign rsp_origin = tt_wide ? wide_own_identifier_q
                              : {8'h00, small_own_identifier_q};

  hdr_pack u_rsp_pack (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(local_acc),
    .tt(rx_tt),
    .ftype(transport_pkg::MAINT_FTYPE),
    .target_identifier(rsp_target),
    .origin_identifier(rsp_origin),
    .hop_count(transport_pkg::HOP_RESPONSE),
    .valid_q(rsp_valid),
    .hdr_q(rsp_header),
    .len_q(rsp_header_len)
  );

  // Writes answer too, with zero data, so no access ever stalls or errors
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_write_q <= 1'b0;
      rsp_rdata_q <= '0;
    end else if (local_acc) begin
      rsp_write_q <= rx_write;
      rsp_rdata_q <= rx_write ? 32'h0000_0000 : rd_word;
    end
  end

  // ----------------------------------------
  // Forwarding
  // ----------------------------------------
  logic [7:0] hop_next;

  assign hop_next = rx_hop_count - 8'h01;

  hdr_pack u_fwd_pack (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(fwd_go),
    .tt(rx_tt),
    .ftype(rx_ftype),
    .target_identifier(rx_target_identifier),
    .origin_identifier(rx_origin_identifier),
    .hop_count(hop_next),
    .valid_q(fwd_valid),
    .hdr_q(fwd_header),
    .len_q(fwd_header_len)
  );

  // Port choice is left to the routing stage via the target identifier
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_target_identifier_q <= '0;
      fwd_write_q <= 1'b0;
      fwd_offset_q <= '0;
      fwd_wdata_q <= '0;
    end else if (fwd_go) begin
      fwd_target_identifier_q <= rx_target_identifier;
      fwd_write_q <= rx_write;
      fwd_offset_q <= rx_offset;
      fwd_wdata_q <= rx_wdata;
    end
  end

  // ----------------------------------------
  // Discard indication
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      discard_q <= 1'b0;
    end else begin
      discard_q <= dropped;
    end
  end

endmodule

// [transport_checker.sv]
// Port assertions for the transport configuration block
`timescale 1ns/1ns
module transport_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Request
  input wire logic rx_valid,
  input wire logic [1:0] rx_tt,
  input wire logic [15:0] rx_origin_identifier,
  input wire logic [7:0] rx_hop_count,
  input wire logic rx_write,
  input wire logic [23:0] rx_offset,
  input wire logic [15:0] rx_target_identifier,
  input wire logic [31:0] rx_wdata,
  // Answers
  input wire logic rsp_valid,
  input wire logic [55:0] rsp_header,
  input wire logic [5:0] rsp_header_len,
  input wire logic rsp_write_q,
  input wire logic [31:0] rsp_rdata_q,
  input wire logic fwd_valid,
  input wire logic [55:0] fwd_header,
  input wire logic [5:0] fwd_header_len,
  input wire logic [15:0] fwd_target_identifier_q,
  input wire logic fwd_write_q,
  input wire logic [23:0] fwd_offset_q,
  input wire logic [31:0] fwd_wdata_q,
  input wire logic discard_q,
  input wire logic [7:0] small_own_identifier_q
);
  // ------------------------------
  // Assertions
  // ------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_one_answer: assert property (rx_valid |=> $onehot({rsp_valid, fwd_valid, discard_q}))
    else $error("request not answered exactly once");
  a_rsp_hop_ff: assert property (rsp_valid |->
    (rsp_header[54] ? rsp_header[17:10] : rsp_header[33:26]) == 8'hFF) else $error("hop not FF");
  a_hdr_len: assert property (rsp_valid |-> rsp_header_len == (rsp_header[54] ? 6'h2E : 6'h1E))
    else $error("header length wrong");
  a_tt_echo: assert property (rx_valid ##1 rsp_valid |-> rsp_header[55:50] == {$past(rx_tt), 4'h8})
    else $error("type code or format misplaced");
  a_swap_origin: assert property (rx_valid && rx_tt == 2'h0 ##1 rsp_valid |->
    rsp_header[49:42] == $past(rx_origin_identifier[7:0])) else $error("target not origin");
  a_reserved_tt: assert property (rx_valid && rx_tt[1] |=> discard_q)
    else $error("reserved type code kept");
  a_fwd_hop: assert property (rx_valid && rx_tt == 2'h0 ##1 fwd_valid |->
    fwd_header[33:26] == $past(rx_hop_count) - 8'h01) else $error("hop not decremented");
  a_fwd_payload: assert property (rx_valid ##1 fwd_valid |->
    fwd_target_identifier_q == $past(rx_target_identifier) && fwd_write_q == $past(rx_write) &&
    fwd_offset_q == $past(rx_offset) && fwd_wdata_q == $past(rx_wdata) &&
    fwd_header_len == (fwd_header[54] ? 6'h2E : 6'h1E)) else $error("forward payload wrong");
  a_write_quiet: assert property (rx_valid && rx_write ##1 rsp_valid |->
    rsp_write_q && rsp_rdata_q == 32'h0) else $error("write answer wrong");
  a_id_by_write: assert property ($changed(small_own_identifier_q) |->
    $past(rx_valid && rx_write && rx_offset[23:2] == 22'h18)) else $error("id changed alone");
endmodule

// [transport_pkg.sv]
// Constants shared by the transport header and configuration logic
// Summary of operation
// - Two-bit type code; only 00 and 01 used
// - Identifiers 8 bits small, 16 bits large
// - Small addresses 256, large 65,536 devices
// - Format type follows the two-bit type code in the header
// - Idless switch accepts maintenance when hops zero
// - Nonzero hops: decrement, forward by target
// - Maintenance responses carry hop count 0xFF
// - Registers 32 bits on aligned words
// - Undefined offsets complete normally, no error
// - Capability area read-only, writes silently dropped
// - Reserved bits and registers read zero
// - Implementation area behaviour is ours
// - Big-endian: bit 0 is most significant
// - Registers accessed as 32-bit words
// - Capability registers returned to maintenance reads
// - Features bit 27 flags large identifiers
// - Identifier bits 8-15 hold small identifier
// - Identifier bits 16-31 hold large identifier
// - Identifier reset values chosen by design
// - Response swaps origin into target field
package transport_pkg;

  // ----------------------------------------
  // Transport type codes and field widths
  // ----------------------------------------
  localparam logic [1:0] TT_SMALL = 2'h0;
  localparam logic [1:0] TT_WIDE = 2'h1;
  localparam int TT_W = 2;
  localparam int SMALL_ID_W = 8;
  localparam int WIDE_ID_W = 16;
  localparam int SMALL_ID_COUNT = 256;
  localparam int WIDE_ID_COUNT = 65536;
  localparam int FTYPE_W = 4;
  localparam logic [3:0] MAINT_FTYPE = 4'h8;
  localparam int HOP_W = 8;
  localparam logic [7:0] HOP_RESPONSE = 8'hFF;

  // ----------------------------------------
  // Serialised header layout, left justified
  // ----------------------------------------
  localparam int HDR_W = 56;
  localparam int HDR_LEN_W = 6;
  localparam logic [5:0] HDR_SMALL_LEN = 6'h1E;
  localparam logic [5:0] HDR_WIDE_LEN = 6'h2E;

  // ----------------------------------------
  // Configuration space
  // ----------------------------------------
  localparam int REG_W = 32;
  localparam int OFFSET_W = 24;
  localparam logic [23:0] OFF_FEATURES = 24'h00_0010;
  localparam logic [23:0] OFF_OWN_ID = 24'h00_0060;
  localparam logic [23:0] CAR_LAST = 24'h00_003C;
  localparam logic [23:0] CSR_LAST = 24'h00_00FC;
  localparam logic [23:0] EXT_LAST = 24'h00_FFFC;

  // Big-endian bit numbers, then their little-endian positions
  localparam int FEAT_LARGE_BE = 27;
  localparam int SMALL_ID_BE_FIRST = 8;
  localparam int WIDE_ID_BE_FIRST = 16;
  localparam int FEAT_LARGE_POS = REG_W - 1 - FEAT_LARGE_BE;
  localparam int SMALL_ID_HI = REG_W - 1 - SMALL_ID_BE_FIRST;
  localparam int WIDE_ID_HI = REG_W - 1 - WIDE_ID_BE_FIRST;

  typedef enum logic [1:0] {
    SPACE_CAR,
    SPACE_CSR,
    SPACE_EXT,
    SPACE_IMPL
  } space_t;

endpackage
